// ### sste_pkg.sv
// Constants, register map and carrier types of the state transition engine
// ----------------------------------------------------------------------------
// Contract
// - All channel values and flags are captured together before each loop's evaluation.
// - Outgoing transitions of a state are tested in ascending priority from one.
// - No true transition means the state stays unchanged through the next loop.
// - A true transition loads its single configured destination state.
// - Outermost compound exits first, then inner compounds, then the simple state.
// - A true border exit leaves the compound whatever inner state is active.
// - A joined transition shares one condition; priority ranks within each source.
// - Each transition has at least one source and exactly one destination.
// - Each state machine offers up to six independent timers.
// - A timed condition is false until its duration elapses, then true.
// - Timer durations reach at least 4,096 hours.
// - Shortest timed transition is bounded by the 60 us loop time.
// - Timers expire no more than 20 us early and within the allowed lateness.
// - Digital input and output fault flags are usable as transition terms.
// - Analog fault, warning and one-hot level flags are usable as terms.
// - Conditions combine terms with NOT, OR and AND.
// ----------------------------------------------------------------------------
package sste_pkg;
    // Timing
    localparam int CLK_MHZ      = 100;
    localparam int US_CYC       = CLK_MHZ;            // Cycles per microsecond
    localparam int LOOP_US      = 60;                 // Worst-case loop time
    localparam int LOOP_CYC     = LOOP_US * CLK_MHZ;  // Cycles per loop
    localparam int TMR_EARLY_US = 20;
    // Sizes
    localparam int NS   = 16;   // States
    localparam int NT   = 8;    // Transition table entries
    localparam int NTMR = 6;    // Timers per machine
    localparam int MAXD = 4;    // Nesting depth
    localparam int TW   = 44;   // Microsecond timer width, covers 4,096 hours
    // Term vector layout
    localparam logic [6:0] TERM_VAR = 7'h40;
    localparam logic [6:0] TERM_TMR = 7'h58;
    // Timer units
    localparam logic [2:0] U_US = 3'h0, U_MS = 3'h1, U_S = 3'h2;
    localparam logic [2:0] U_MIN = 3'h3, U_HR = 3'h4, U_DAY = 3'h5;
    // Condition operators
    localparam logic [1:0] OP_A = 2'h0, OP_AND = 2'h1, OP_OR = 2'h2;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] VARS_OFS   = 8'h08;
    localparam logic [7:0] INIT_OFS   = 8'h0c;
    localparam logic [7:0] SCFG_OFS   = 8'h10;
    localparam logic [7:0] TRA_OFS    = 8'h50;
    localparam logic [7:0] TRB_OFS    = 8'h70;
    localparam logic [7:0] TMR_OFS    = 8'h90;
    localparam logic [7:0] END_OFS    = 8'ha8;
    // Reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [3:0]  INIT_RST = 4'h0;

    // Synchronised channel flags, one bit per channel in each field except ai_level, which has five
    typedef struct packed {
        logic [3:0][4:0] ai_level;  // Lower alarm, low, normal, high, upper alarm
        logic [3:0]      ai_warn;
        logic [3:0]      ai_mis;
        logic [3:0]      ai_oc;
        logic [3:0]      do_pulse;
        logic [3:0]      do_broken;
        logic [3:0]      do_oc;
        logic [3:0]      do_echo;
        logic [3:0]      di_pulse;
        logic [3:0]      di_oc;
        logic [3:0]      di_mis;
        logic [3:0]      di_val;
    } chan_in_t;

    typedef struct packed {
        logic       compound;
        logic [3:0] init_child;
        logic       has_parent;
        logic [3:0] parent;
    } state_cfg_t;

    typedef struct packed {
        logic            valid;
        logic [6:0]      rsv;
        logic [3:0]      prio;
        logic [3:0]      dest;
        logic [NS-1:0]   src;
    } trans_a_t;

    typedef struct packed {
        logic [13:0] rsv;
        logic [1:0]  op;
        logic        inv_b;
        logic [6:0]  term_b;
        logic        inv_a;
        logic [6:0]  term_a;
    } trans_b_t;

    typedef struct packed {
        logic [3:0]  owner;
        logic        rsv;
        logic [2:0]  unit;
        logic [23:0] value;
    } timer_cfg_t;
endpackage

// ### sste_top.sv
// Transition evaluation engine with APB register file and state timers
`timescale 1ns/1ps
`default_nettype none
module sste_top #(
    parameter int LOOP_CYC = sste_pkg::LOOP_CYC
) (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire sste_pkg::chan_in_t chan_in,
    output logic      [3:0]         state,
    output logic                    state_changed,
    output logic                    loop_strobe
);
    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    sste_pkg::chan_in_t                   s1_ff, s2_ff, s3_ff, stable_ff, snap_ff;
    sste_pkg::state_cfg_t [sste_pkg::NS-1:0] scfg_ff;
    sste_pkg::trans_a_t   [sste_pkg::NT-1:0] tra_ff;
    sste_pkg::trans_b_t   [sste_pkg::NT-1:0] trb_ff;
    sste_pkg::timer_cfg_t [sste_pkg::NTMR-1:0] tcfg_ff;
    logic [sste_pkg::TW-1:0] tcnt_ff [sste_pkg::NTMR];
    logic [31:0]  ctrl_ff, prdata_ff;
    logic [23:0]  vars_ff;
    logic [3:0]   init_ff, state_ff, last_win_ff;
    logic         pready_ff, pslverr_ff, eval_ff, changed_ff, tick_ff;
    logic [15:0]  loop_cnt_ff;
    logic [7:0]   us_cnt_ff;
    logic         us_tick_ff;
    logic         run;
    // ------------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------------
    // Mask of the state and all compounds that enclose it
    function automatic logic [sste_pkg::NS-1:0] chain_mask(
        input logic [3:0] s, input sste_pkg::state_cfg_t [sste_pkg::NS-1:0] c);
        logic [sste_pkg::NS-1:0] m;
        logic [3:0] p;
        logic       go;
        m  = '0;
        p  = s;
        go = 1'b1;
        for (int k = 0; k < sste_pkg::MAXD; k++) begin
            if (go) begin
                m[p] = 1'b1;
                go   = c[p].has_parent;
                p    = c[p].parent;
            end
        end
        return m;
    endfunction
    // Descend into initial children until a simple state is reached
    function automatic logic [3:0] resolve(
        input logic [3:0] s, input sste_pkg::state_cfg_t [sste_pkg::NS-1:0] c);
        logic [3:0] r;
        r = s;
        for (int k = 0; k < sste_pkg::MAXD; k++) begin
            if (c[r].compound) begin
                r = c[r].init_child;
            end
        end
        return r;
    endfunction
    // Microsecond weight of one timer unit
    function automatic logic [sste_pkg::TW-1:0] unit_us(input logic [2:0] u);
        case (u)
            sste_pkg::U_US:  unit_us = 44'h1;
            sste_pkg::U_MS:  unit_us = 44'd1000;
            sste_pkg::U_S:   unit_us = 44'd1000000;
            sste_pkg::U_MIN: unit_us = 44'd60000000;
            sste_pkg::U_HR:  unit_us = 44'd3600000000;
            sste_pkg::U_DAY: unit_us = 44'd86400000000;
            default:         unit_us = 44'h1;
        endcase
    endfunction

    // ------------------------------------------------------------------------
    // Input synchroniser and loop snapshot
    // ------------------------------------------------------------------------
    // Three stages; a bit only moves once stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_ff     <= '0;
            s2_ff     <= '0;
            s3_ff     <= '0;
            stable_ff <= '0;
        end else begin
            s1_ff     <= chan_in;
            s2_ff     <= s1_ff;
            s3_ff     <= s2_ff;
            stable_ff <= (s2_ff & s3_ff) | (stable_ff & (s2_ff | s3_ff));
        end
    end

    // One common capture instant per loop, a cycle ahead of evaluation
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            snap_ff <= '0;
        end else if (tick_ff) begin
            snap_ff <= stable_ff;
        end
    end

    // ------------------------------------------------------------------------
    // Loop and microsecond time bases
    // ------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loop_cnt_ff <= '0;
            tick_ff     <= 1'b0;
            eval_ff     <= 1'b0;
            us_cnt_ff   <= '0;
            us_tick_ff  <= 1'b0;
        end else begin
            tick_ff     <= (loop_cnt_ff == 16'(LOOP_CYC - 2));
            loop_cnt_ff <= (loop_cnt_ff == 16'(LOOP_CYC - 1)) ? '0 : loop_cnt_ff + 16'h1;
            eval_ff     <= tick_ff;
            us_tick_ff  <= (us_cnt_ff == 8'(sste_pkg::US_CYC - 2));
            us_cnt_ff   <= (us_cnt_ff == 8'(sste_pkg::US_CYC - 1)) ? '0 : us_cnt_ff + 8'h1;
        end
    end

    // ------------------------------------------------------------------------
    // Term vector and condition evaluation
    // ------------------------------------------------------------------------
    wire [sste_pkg::NTMR-1:0] tmr_done;
    wire [127:0] terms = {34'h0, tmr_done, vars_ff, snap_ff};
    wire [sste_pkg::NS-1:0] cur_mask = chain_mask(state_ff, scfg_ff);
    assign run = ctrl_ff[0];

    logic [sste_pkg::NT-1:0] hit;
    logic [1:0] lvl [sste_pkg::NT];
    // Term combine and level of the outermost active source of each entry
    always_comb begin
        logic       a, b, go;
        logic [3:0] p;
        a   = 1'b0;
        b   = 1'b0;
        go  = 1'b0;
        p   = '0;
        hit = '0;
        for (int t = 0; t < sste_pkg::NT; t++) begin
            a = terms[trb_ff[t].term_a] ^ trb_ff[t].inv_a;
            b = terms[trb_ff[t].term_b] ^ trb_ff[t].inv_b;
            lvl[t] = 2'(sste_pkg::MAXD - 1);
            p  = state_ff;
            go = 1'b1;
            for (int k = 0; k < sste_pkg::MAXD; k++) begin
                // Later (outer) ancestors overwrite, so outermost wins
                if (go && tra_ff[t].src[p]) begin
                    lvl[t] = 2'(sste_pkg::MAXD - 1 - k);
                end
                go = go & scfg_ff[p].has_parent;
                p  = scfg_ff[p].parent;
            end
            // Empty source mask never fires; one destination field only
            hit[t] = tra_ff[t].valid && |(tra_ff[t].src & cur_mask) &&
                     ((trb_ff[t].op == sste_pkg::OP_AND) ? (a & b) :
                      (trb_ff[t].op == sste_pkg::OP_OR)  ? (a | b) : a);
        end
    end

    // Smallest key of level, priority, index below 9'h1ff picks the winner
    logic [2:0] win;
    logic       any_hit;
    always_comb begin
        logic [8:0] best;
        best    = 9'h1ff;
        win     = '0;
        any_hit = 1'b0;
        for (int t = 0; t < sste_pkg::NT; t++) begin
            if (hit[t] && {lvl[t], tra_ff[t].prio, 3'(t)} < best) begin
                best    = {lvl[t], tra_ff[t].prio, 3'(t)};
                win     = 3'(t);
                any_hit = 1'b1;
            end
        end
    end

    wire [3:0] next_state = resolve(tra_ff[win].dest, scfg_ff);
    wire       fire       = eval_ff && run && any_hit;
    wire [sste_pkg::NS-1:0] new_mask = chain_mask(next_state, scfg_ff);

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    // Stopped engine parks on the initial state, resolved to a simple one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff    <= sste_pkg::INIT_RST;
            last_win_ff <= '0;
            changed_ff  <= 1'b0;
        end else begin
            changed_ff <= fire;
            if (!run) begin
                state_ff <= resolve(init_ff, scfg_ff);
            end else if (fire) begin
                state_ff    <= next_state;
                last_win_ff <= {1'b0, win};
            end
        end
    end

    // ------------------------------------------------------------------------
    // Timers
    // ------------------------------------------------------------------------
    // Microsecond counters; range 2^44 us holds 4,096 hours with margin
    for (genvar k = 0; k < sste_pkg::NTMR; k++) begin : g_tmr
        wire [sste_pkg::TW-1:0] limit =
            sste_pkg::TW'(tcfg_ff[k].value * unit_us(tcfg_ff[k].unit));
        wire [3:0] own = tcfg_ff[k].owner;
        wire restart = !run || (fire && new_mask[own] &&
                                (!cur_mask[own] || own == next_state));
        assign tmr_done[k] = (tcnt_ff[k] >= limit);
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                tcnt_ff[k] <= '0;
            end else if (restart) begin
                tcnt_ff[k] <= '0;
            end else if (us_tick_ff && !tmr_done[k]) begin
                tcnt_ff[k] <= tcnt_ff[k] + 44'h1;
            end
        end
        // Restart always empties the counter
        property p_tmr_restart;
            @(posedge pclk) disable iff (!presetn) restart |=> tcnt_ff[k] == '0;
        endproperty
        a_tmr_restart: assert property (p_tmr_restart) else $error("timer not restarted");
        // Done only appears after a counted microsecond, a new limit or a zero limit
        property p_tmr_early;
            @(posedge pclk) disable iff (!presetn)
                $rose(tmr_done[k]) |-> $past(us_tick_ff) || $changed(limit) || limit == '0;
        endproperty
        a_tmr_early: assert property (p_tmr_early) else $error("timer expired early");
        c_tmr_done: cover property (@(posedge pclk) disable iff (!presetn) $rose(tmr_done[k]));
    end

    // ------------------------------------------------------------------------
    // APB register file
    // ------------------------------------------------------------------------
    wire        acc    = psel && penable && !pready_ff;
    wire [5:0]  widx   = paddr[7:2];
    wire        in_map = paddr < sste_pkg::END_OFS;
    wire [31:0] status = {15'h0, run, 4'h0, last_win_ff, 4'h0, state_ff};
    wire [5:0]  sidx   = widx - 6'(sste_pkg::SCFG_OFS >> 2);
    wire [5:0]  aidx   = widx - 6'(sste_pkg::TRA_OFS >> 2);
    wire [5:0]  bidx   = widx - 6'(sste_pkg::TRB_OFS >> 2);
    wire [5:0]  tidx   = widx - 6'(sste_pkg::TMR_OFS >> 2);
    wire is_s = paddr >= sste_pkg::SCFG_OFS && paddr < sste_pkg::TRA_OFS;
    wire is_a = paddr >= sste_pkg::TRA_OFS && paddr < sste_pkg::TRB_OFS;
    wire is_b = paddr >= sste_pkg::TRB_OFS && paddr < sste_pkg::TMR_OFS;
    wire is_t = paddr >= sste_pkg::TMR_OFS && in_map;
    wire [31:0] rd_val =
        (paddr == sste_pkg::CTRL_OFS)   ? ctrl_ff :
        (paddr == sste_pkg::STATUS_OFS) ? status :
        (paddr == sste_pkg::VARS_OFS)   ? {8'h0, vars_ff} :
        (paddr == sste_pkg::INIT_OFS)   ? {28'h0, init_ff} :
        is_s ? {22'h0, scfg_ff[sidx[3:0]]} :
        is_a ? (tra_ff[aidx[2:0]] & 32'h80ff_ffff) :
        is_b ? (trb_ff[bidx[2:0]] & 32'h0003_ffff) :
        is_t ? (tcfg_ff[tidx[2:0]] & 32'hf7ff_ffff) : 32'h0;
    wire wr_ok = psel && penable && pready_ff && pwrite && in_map && !paddr[1] && !paddr[0];

    // One wait state: pready rises in the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= '0;
        end else begin
            pready_ff  <= acc;
            pslverr_ff <= acc && !in_map;
            prdata_ff  <= (acc && !pwrite) ? rd_val : 32'h0;
        end
    end

    // Writes land only at the edge that completes the transfer, pready high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= sste_pkg::CTRL_RST;
            vars_ff <= '0;
            init_ff <= sste_pkg::INIT_RST;
            scfg_ff <= '0;
            tra_ff  <= '0;
            trb_ff  <= '0;
            tcfg_ff <= '0;
        end else if (wr_ok) begin
            if (paddr == sste_pkg::CTRL_OFS) ctrl_ff <= {31'h0, pwdata[0]};
            if (paddr == sste_pkg::VARS_OFS) vars_ff <= pwdata[23:0];
            if (paddr == sste_pkg::INIT_OFS) init_ff <= pwdata[3:0];
            if (is_s) scfg_ff[sidx[3:0]] <= pwdata[9:0];
            if (is_a) tra_ff[aidx[2:0]]  <= pwdata & 32'h80ff_ffff;
            if (is_b) trb_ff[bidx[2:0]]  <= pwdata & 32'h0003_ffff;
            if (is_t) tcfg_ff[tidx[2:0]] <= pwdata & 32'hf7ff_ffff;
        end
    end

    assign prdata        = prdata_ff;
    assign pready        = pready_ff;
    assign pslverr       = pslverr_ff;
    assign state         = state_ff;
    assign state_changed = changed_ff;
    assign loop_strobe   = eval_ff;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    logic better_exists;
    // Independent search for a hit that should have outranked the winner
    always_comb begin
        better_exists = 1'b0;
        for (int t = 0; t < sste_pkg::NT; t++) begin
            if (hit[t] && (lvl[t] < lvl[win] ||
                (lvl[t] == lvl[win] && tra_ff[t].prio < tra_ff[win].prio))) begin
                better_exists = 1'b1;
            end
        end
    end

    property p_snap_hold;
        @(posedge pclk) disable iff (!presetn) !tick_ff |=> $stable(snap_ff);
    endproperty
    a_snap_hold: assert property (p_snap_hold) else $error("snapshot moved mid loop");
    property p_best;
        @(posedge pclk) disable iff (!presetn) (eval_ff && any_hit) |-> !better_exists;
    endproperty
    a_best: assert property (p_best) else $error("lower ranked transition won");
    property p_outer;
        @(posedge pclk) disable iff (!presetn)
            (eval_ff && any_hit) |-> hit[win] && lvl[win] <= lvl[0] || !hit[0];
    endproperty
    a_outer: assert property (p_outer) else $error("inner exit beat outer exit");
    property p_keep;
        @(posedge pclk) disable iff (!presetn)
            (run && !(eval_ff && any_hit)) ##1 run |-> $stable(state_ff);
    endproperty
    a_keep: assert property (p_keep) else $error("state moved without a true transition");
    property p_load;
        @(posedge pclk) disable iff (!presetn) fire |=> state_ff == $past(next_state);
    endproperty
    a_load: assert property (p_load) else $error("destination not loaded");
    property p_src;
        @(posedge pclk) disable iff (!presetn) fire |-> (tra_ff[win].src != '0);
    endproperty
    a_src: assert property (p_src) else $error("transition without source fired");
    property p_loop_gap;
        @(posedge pclk) disable iff (!presetn) tick_ff |=> !tick_ff [*8];
    endproperty
    a_loop_gap: assert property (p_loop_gap) else $error("loops too close");
    property p_eval_after_snap;
        @(posedge pclk) disable iff (!presetn) tick_ff |=> eval_ff ##1 !eval_ff;
    endproperty
    a_eval_after_snap: assert property (p_eval_after_snap) else $error("eval not after snap");
    property p_apb_ans;
        @(posedge pclk) disable iff (!presetn) acc |=> pready_ff ##1 !pready_ff;
    endproperty
    a_apb_ans: assert property (p_apb_ans) else $error("apb answer timing wrong");

    c_fire:  cover property (@(posedge pclk) disable iff (!presetn) fire);
    c_idle:  cover property (@(posedge pclk) disable iff (!presetn) eval_ff && run && !any_hit);
    c_outer: cover property (@(posedge pclk) disable iff (!presetn) fire && lvl[win] == 2'h0);
endmodule
`default_nettype wire

// ### chan_model.sv
// Model of the safety channel hardware feeding the engine
`timescale 1ns/1ps
`default_nettype none
module chan_model (
    input  wire logic               pclk,
    input  wire logic [63:0]        want,
    output sste_pkg::chan_in_t      chan_in
);
    // ------------------------------------------------------------
    // Channel flags
    // ------------------------------------------------------------
    // Flags move off the engine clock's sampling edge, as real channels would
    always_ff @(posedge pclk) begin
        chan_in <= #2 want;
    end
endmodule
`default_nettype wire

// ### testbench.sv
// Self-checking bench of the state transition engine
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int LC = 50;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, state_changed, loop_strobe;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] state;
    logic [63:0] want;
    logic err;
    sste_pkg::chan_in_t chan_in;
    int mismatches, comparisons, cycles;

    sste_top #(.LOOP_CYC(LC)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .chan_in(chan_in), .state(state),
        .state_changed(state_changed), .loop_strobe(loop_strobe));
    chan_model partner (.pclk(pclk), .want(want), .chan_in(chan_in));

    // ------------------------------------------------------------
    // Clock and hang guard
    // ------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            results();
        end
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    // One APB transfer; waits for pready without assuming a latency
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // Bounded wait for the state output to reach a value
    task automatic wait_state(input logic [3:0] s, input int lim);
        int n;
        n = 0;
        while (state !== s && n < lim) begin
            @(posedge pclk);
            n++;
        end
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Reset values, read-only status and an unmapped place
    task automatic regs_scn();
        apb(1'b0, sste_pkg::CTRL_OFS, 32'h0);
        check(rd, sste_pkg::CTRL_RST);
        apb(1'b1, sste_pkg::STATUS_OFS, 32'hffff_ffff);
        apb(1'b0, sste_pkg::STATUS_OFS, 32'h0);
        check(rd, 32'h0);
        apb(1'b1, sste_pkg::VARS_OFS, 32'hffab_cdef);
        apb(1'b0, sste_pkg::VARS_OFS, 32'h0);
        check(rd, 32'h00ab_cdef);
        apb(1'b0, sste_pkg::END_OFS, 32'h0);
        check({31'h0, err}, 32'h1);
        check(rd, 32'h0);
    endtask
    // Two true exits from state 0: lower priority number wins over table order
    task automatic prio_scn();
        for (int s = 0; s < 4; s++) apb(1'b1, 8'(sste_pkg::SCFG_OFS + 4 * s), 32'h0);
        apb(1'b1, sste_pkg::TRA_OFS, 32'h8021_0001);
        apb(1'b1, sste_pkg::TRB_OFS, 32'h0);
        apb(1'b1, 8'h54, 32'h8012_0001);
        apb(1'b1, 8'h74, 32'h0);
        apb(1'b1, 8'h58, 32'h8013_0004);
        apb(1'b1, 8'h78, 32'h0000_0058);
        apb(1'b1, sste_pkg::TMR_OFS, 32'h2000_0005);
        apb(1'b1, sste_pkg::CTRL_OFS, 32'h1);
        repeat (5 * LC) @(posedge pclk);
        check({28'h0, state}, 32'h0);
        want <= 64'h1;
        wait_state(4'h2, 3 * LC);
        check({28'h0, state}, 32'h2);
        check({31'h0, state_changed}, 32'h1);
    endtask
    // Timed exit: false until 5 us after entry, then true
    task automatic timer_scn();
        int n;
        n = 0;
        repeat (350) @(posedge pclk);
        check({28'h0, state}, 32'h2);
        wait_state(4'h3, 400);
        check({28'h0, state}, 32'h3);
        repeat (4 * LC) begin
            @(posedge pclk);
            n += loop_strobe;
        end
        check({28'h0, state}, 32'h3);
        check(32'(n), 32'h4);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {psel, penable, pwrite, paddr, pwdata, want} = '0;
        {mismatches, comparisons, cycles} = '0;
        presetn = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        regs_scn();
        prio_scn();
        timer_scn();
        results();
    end
endmodule
`default_nettype wire
